// ==== common/ldc_pkg.sv ====
package ldc_pkg;

   localparam int DW = 16;
   localparam int AW = 8;

   // Register offsets
   localparam logic [7:0] REG_BB_DATA   = 8'h00;
   localparam logic [7:0] REG_IR_DATA   = 8'h01;
   localparam logic [7:0] REG_CTRL      = 8'h02;
   localparam logic [7:0] REG_PERSIST   = 8'h03;
   localparam logic [7:0] REG_IMM_LOW   = 8'h04;
   localparam logic [7:0] REG_IMM_HIGH  = 8'h05;
   localparam logic [7:0] REG_PERS_LOW  = 8'h06;
   localparam logic [7:0] REG_PERS_HIGH = 8'h07;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_MASK      = 8'h09;

   // Control fields
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_ITS_LSB = 4;
   localparam int ITS_W        = 3;
   localparam logic [15:0] CTRL_RESET = 16'h0001;

   localparam int PERSIST_W = 4;
   localparam logic [3:0] PERSIST_RESET = 4'h1;

   localparam logic [15:0] LOW_RESET  = 16'h0000;
   localparam logic [15:0] HIGH_RESET = 16'hffff;

   // Status and mask bits
   localparam int STAT_DONE = 0;
   localparam int STAT_IMM  = 1;
   localparam int STAT_PERS = 2;
   localparam int STAT_W    = 3;
   localparam logic [2:0] MASK_RESET = 3'h0;

   // Timing
   localparam int CLK_HZ      = 40_000_000;
   localparam int STEP_MS     = 100;
   localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
   localparam logic [2:0] ITS_MAX = 3'h5;

   // Bus address, value is arbitrary
   localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h3a;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } ldc_req_t;

   typedef struct packed {
      logic [15:0] bb;
      logic [15:0] ir;
   } ldc_result_t;

   typedef struct packed {
      logic [15:0] low;
      logic [15:0] high;
   } ldc_limits_t;

endpackage

// ==== core/ldc_conv.sv ====
`timescale 1ns/100ps
`default_nettype none
module ldc_conv #(
   parameter int step_cycles = ldc_pkg::STEP_CYCLES
) (
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                enable,
   input  wire logic [2:0]          its,
   input  wire logic [1:0]          pulse_in,
   output ldc_pkg::ldc_result_t     result,
   output logic                     done
);

   logic [31:0]      tick;
   logic [2:0]       step;
   logic [2:0]       steps_last;
   logic             period_end;
   logic [1:0][15:0] acc;
   logic [1:0][15:0] res;

   assign steps_last = (its > ldc_pkg::ITS_MAX) ? ldc_pkg::ITS_MAX : its;
   assign period_end = enable && (tick == 32'(step_cycles - 1))
                       && (step == steps_last);

   always_ff @(posedge mclk) begin
      if (!rst_n || !enable) begin
         tick <= 32'h0;
         step <= 3'h0;
      end else if (tick == 32'(step_cycles - 1)) begin
         tick <= 32'h0;
         step <= (step == steps_last) ? 3'h0 : step + 3'h1;
      end else begin
         tick <= tick + 32'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         done <= 1'b0;
      end else begin
         done <= period_end;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_ch
         logic s1, s2, s3;
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end else begin
               s1 <= pulse_in[g];
               s2 <= s1;
               s3 <= s2;
            end
         end
         always_ff @(posedge mclk) begin
            if (!rst_n || !enable) begin
               acc[g] <= 16'h0000;
               res[g] <= 16'h0000;
            end else if (period_end) begin
               res[g] <= acc[g];
               acc[g] <= 16'h0000;
            end else if (s2 && !s3 && acc[g] != 16'hffff) begin
               acc[g] <= acc[g] + 16'h0001;
            end
         end
      end
   endgenerate

   assign result.bb = res[0];
   assign result.ir = res[1];

endmodule
`default_nettype wire

// ==== core/ldc_thresh.sv ====
`timescale 1ns/100ps
`default_nettype none
module ldc_thresh #(
   parameter bit filtered = 1'b0
) (
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                sample,
   input  wire logic [15:0]         value,
   input  wire ldc_pkg::ldc_limits_t limits,
   input  wire logic [3:0]          persist,
   output logic                     hit
);

   logic       outside;
   logic [3:0] run;
   logic [3:0] target;

   assign outside = (value > limits.high) || (value < limits.low);
   assign target  = (persist == 4'h0) ? 4'h1 : persist;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         run <= 4'h0;
      end else if (sample) begin
         if (!outside) begin
            run <= 4'h0;
         end else if (run < target) begin
            run <= run + 4'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hit <= 1'b0;
      end else if (!filtered) begin
         hit <= sample && outside;
      end else begin
         hit <= sample && outside && (run >= target - 4'h1);
      end
   end

endmodule
`default_nettype wire

// ==== core/ldc_top.sv ====
// Behaviour
// - Both channels integrate over one window
// - Results go to registers zero, one
// - Result transfer is double buffered
// - Next integration starts by itself
// - Interrupt level holds until host clears
// - Out-of-limit conversion raises interrupt
// - Two independent upper/lower threshold sets
// - One set filtered by persistence
// - Other set interrupts on first hit
// - Interrupt pin open drain, pulled low
// - Two-wire bus, at most 400 kbit/s
// - Integration in 100 ms steps
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ldc_top #(
   parameter int         step_cycles = ldc_pkg::STEP_CYCLES,
   parameter logic [6:0] i2c_addr    = ldc_pkg::I2C_ADDR_DEFAULT
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic [15:0]      bus_rdata,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic        bb_pulse,
   input  wire logic        ir_pulse,
   output logic             int_out,
   output logic             int_oe_n,
   output logic             irq
);

   typedef enum {
      I_IDLE, I_ADDR, I_ACK_A, I_WR, I_ACK_W, I_RD, I_ACK_R
   } ldc_i2c_state_t;

   ldc_i2c_state_t       state;
   logic                 scl_s1, scl_s2, scl_s3;
   logic                 sda_s1, sda_s2, sda_s3;
   logic                 scl_rise, scl_fall, bus_start, bus_stop;
   logic [7:0]           shreg;
   logic [3:0]           bitcnt;
   logic                 rw, first, hi;
   logic [7:0]           ptr;
   logic [7:0]           lo_byte;
   logic [7:0]           next_byte;
   ldc_pkg::ldc_req_t    issue;
   ldc_pkg::ldc_req_t    pend;
   logic [15:0]          i2c_rdata;

   logic                 bus_act, i2c_go;
   logic                 acc_wr, acc_rd;
   logic [7:0]           acc_addr;
   logic [15:0]          acc_wdata;
   logic [15:0]          rd_val;

   logic [15:0]          ctrl;
   logic [3:0]           persist;
   ldc_pkg::ldc_limits_t lim [2];
   logic [2:0]           status;
   logic [2:0]           mask;
   logic [2:0]           next_status;
   logic [15:0]          data_bb, data_ir, ir_hold;

   ldc_pkg::ldc_result_t result;
   logic                 conv_done;
   logic [1:0]           hits;

   // Pin synchronisers; edges read only the second and third stages
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
      end
   end

   assign scl_rise  = scl_s2 && !scl_s3;
   assign scl_fall  = !scl_s2 && scl_s3;
   assign bus_start = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
   assign bus_stop  = scl_s2 && scl_s3 && sda_s2 && !sda_s3;
   assign next_byte = hi ? i2c_rdata[7:0] : i2c_rdata[15:8];

   // Two-wire target: pointer, then low and high bytes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state    <= I_IDLE;
         shreg    <= 8'h00;
         bitcnt   <= 4'h0;
         rw       <= 1'b0;
         first    <= 1'b0;
         hi       <= 1'b0;
         ptr      <= 8'h00;
         lo_byte  <= 8'h00;
         sda_oe_n <= 1'b1;
         issue    <= '0;
      end else begin
         issue <= '0;
         if (bus_stop) begin
            state    <= I_IDLE;
            sda_oe_n <= 1'b1;
         end else if (bus_start) begin
            state    <= I_ADDR;
            bitcnt   <= 4'h0;
            sda_oe_n <= 1'b1;
         end else if (scl_rise) begin
            unique case (state)
               I_ADDR, I_WR: begin
                  shreg  <= {shreg[6:0], sda_s2};
                  bitcnt <= bitcnt + 4'h1;
               end
               I_ACK_R: begin
                  if (sda_s2) begin
                     state <= I_IDLE;
                  end
               end
               I_IDLE, I_ACK_A, I_ACK_W, I_RD: begin
               end
            endcase
         end else if (scl_fall) begin
            unique case (state)
               I_ADDR: begin
                  if (bitcnt == 4'h8 && shreg[7:1] == i2c_addr) begin
                     state    <= I_ACK_A;
                     sda_oe_n <= 1'b0;
                     rw       <= shreg[0];
                     issue.rd <= shreg[0];
                     issue.addr <= ptr;
                  end else if (bitcnt == 4'h8) begin
                     state <= I_IDLE;
                  end
               end
               I_ACK_A: begin
                  bitcnt <= 4'h0;
                  hi     <= 1'b0;
                  if (rw) begin
                     state    <= I_RD;
                     sda_oe_n <= i2c_rdata[7];
                     shreg    <= {i2c_rdata[6:0], 1'b0};
                  end else begin
                     state    <= I_WR;
                     sda_oe_n <= 1'b1;
                     first    <= 1'b1;
                  end
               end
               I_WR: begin
                  if (bitcnt == 4'h8) begin
                     state    <= I_ACK_W;
                     sda_oe_n <= 1'b0;
                     if (first) begin
                        ptr   <= shreg;
                        first <= 1'b0;
                     end else if (!hi) begin
                        lo_byte <= shreg;
                        hi      <= 1'b1;
                     end else begin
                        issue.wr    <= 1'b1;
                        issue.addr  <= ptr;
                        issue.wdata <= {shreg, lo_byte};
                        ptr         <= ptr + 8'h01;
                        hi          <= 1'b0;
                     end
                  end
               end
               I_ACK_W: begin
                  state    <= I_WR;
                  sda_oe_n <= 1'b1;
                  bitcnt   <= 4'h0;
               end
               I_RD: begin
                  if (bitcnt == 4'h7) begin
                     state    <= I_ACK_R;
                     sda_oe_n <= 1'b1;
                     if (hi) begin
                        issue.rd   <= 1'b1;
                        issue.addr <= ptr + 8'h01;
                        ptr        <= ptr + 8'h01;
                     end
                  end else begin
                     sda_oe_n <= shreg[7];
                     shreg    <= {shreg[6:0], 1'b0};
                     bitcnt   <= bitcnt + 4'h1;
                  end
               end
               I_ACK_R: begin
                  state    <= I_RD;
                  bitcnt   <= 4'h0;
                  hi       <= !hi;
                  sda_oe_n <= next_byte[7];
                  shreg    <= {next_byte[6:0], 1'b0};
               end
               I_IDLE: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sda_out <= 1'b0;
         int_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         int_out <= 1'b0;
      end
   end

   // Serial accesses wait for a cycle free of port strobes
   assign bus_act   = bus_wr || bus_rd;
   assign i2c_go    = (pend.rd || pend.wr) && !bus_act;
   assign acc_wr    = bus_wr || (i2c_go && pend.wr);
   assign acc_rd    = bus_rd || (i2c_go && pend.rd);
   assign acc_addr  = bus_act ? bus_addr : pend.addr;
   assign acc_wdata = bus_act ? bus_wdata : pend.wdata;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pend <= '0;
      end else if (issue.rd || issue.wr) begin
         pend <= issue;
      end else if (i2c_go) begin
         pend <= '0;
      end
   end

   always_comb begin
      rd_val = 16'h0000;
      unique case (acc_addr)
         ldc_pkg::REG_BB_DATA:   rd_val = data_bb;
         ldc_pkg::REG_IR_DATA:   rd_val = ir_hold;
         ldc_pkg::REG_CTRL:      rd_val = ctrl;
         ldc_pkg::REG_PERSIST:   rd_val = {12'h000, persist};
         ldc_pkg::REG_IMM_LOW:   rd_val = lim[0].low;
         ldc_pkg::REG_IMM_HIGH:  rd_val = lim[0].high;
         ldc_pkg::REG_PERS_LOW:  rd_val = lim[1].low;
         ldc_pkg::REG_PERS_HIGH: rd_val = lim[1].high;
         ldc_pkg::REG_STATUS:    rd_val = {13'h0000, status};
         ldc_pkg::REG_MASK:      rd_val = {13'h0000, mask};
         default:                rd_val = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bus_rdata <= 16'h0000;
         i2c_rdata <= 16'h0000;
      end else begin
         bus_rdata <= bus_rd ? rd_val : 16'h0000;
         if (i2c_go && pend.rd) begin
            i2c_rdata <= rd_val;
         end
      end
   end

   // Two limit sets, persistence and control
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl        <= ldc_pkg::CTRL_RESET;
         persist     <= ldc_pkg::PERSIST_RESET;
         lim[0].low  <= ldc_pkg::LOW_RESET;
         lim[0].high <= ldc_pkg::HIGH_RESET;
         lim[1].low  <= ldc_pkg::LOW_RESET;
         lim[1].high <= ldc_pkg::HIGH_RESET;
         mask        <= ldc_pkg::MASK_RESET;
      end else if (acc_wr) begin
         unique case (acc_addr)
            ldc_pkg::REG_CTRL:      ctrl        <= acc_wdata;
            ldc_pkg::REG_PERSIST:   persist     <= acc_wdata[3:0];
            ldc_pkg::REG_IMM_LOW:   lim[0].low  <= acc_wdata;
            ldc_pkg::REG_IMM_HIGH:  lim[0].high <= acc_wdata;
            ldc_pkg::REG_PERS_LOW:  lim[1].low  <= acc_wdata;
            ldc_pkg::REG_PERS_HIGH: lim[1].high <= acc_wdata;
            ldc_pkg::REG_MASK:      mask        <= acc_wdata[2:0];
            default: begin
            end
         endcase
      end
   end

   ldc_conv #(
      .step_cycles (step_cycles)
   ) u_conv (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .enable   (ctrl[ldc_pkg::CTRL_EN_BIT]),
      .its      (ctrl[ldc_pkg::CTRL_ITS_LSB +: ldc_pkg::ITS_W]),
      .pulse_in ({ir_pulse, bb_pulse}),
      .result   (result),
      .done     (conv_done)
   );

   // Both results land in one cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         data_bb <= 16'h0000;
         data_ir <= 16'h0000;
      end else if (conv_done) begin
         data_bb <= result.bb;
         data_ir <= result.ir;
      end
   end

   // Infrared word frozen on broadband read
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ir_hold <= 16'h0000;
      end else if (acc_rd && acc_addr == ldc_pkg::REG_BB_DATA) begin
         ir_hold <= data_ir;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_thr
         ldc_thresh #(
            .filtered (g == 1)
         ) u_thr (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .sample  (conv_done),
            .value   (result.bb),
            .limits  (lim[g]),
            .persist (persist),
            .hit     (hits[g])
         );
      end
   endgenerate

   // Sticky until read; a new event wins over the clear
   always_comb begin
      next_status = status;
      if (acc_rd && acc_addr == ldc_pkg::REG_STATUS) begin
         next_status = 3'h0;
      end
      next_status[ldc_pkg::STAT_DONE] = next_status[ldc_pkg::STAT_DONE]
                                        | conv_done;
      next_status[ldc_pkg::STAT_IMM]  = next_status[ldc_pkg::STAT_IMM]
                                        | hits[0];
      next_status[ldc_pkg::STAT_PERS] = next_status[ldc_pkg::STAT_PERS]
                                        | hits[1];
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status <= 3'h0;
      end else begin
         status <= next_status;
      end
   end

   // Pin pulled low while an unmasked event stands
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq      <= 1'b0;
         int_oe_n <= 1'b1;
      end else begin
         irq      <= |(status & mask);
         int_oe_n <= ~(|(status & mask));
      end
   end

endmodule
`default_nettype wire

// ==== sim/ldc_i2c_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module ldc_i2c_host (
   output logic     scl,
   output logic     sda_pull,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic xfer(input logic [8:0] t, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         #25 sda_pull = !t[i];
         #75 scl = 1'b1;
         #50 r[i] = sda;
         #50 scl = 1'b0;
      end
   endtask
   task automatic start;
      #25 sda_pull = 1'b0;
      #75 scl = 1'b1;
      #50 sda_pull = 1'b1;
      #50 scl = 1'b0;
   endtask
   // Clock stays high between frames
   task automatic stop;
      #25 sda_pull = 1'b1;
      #75 scl = 1'b1;
      #50 sda_pull = 1'b0;
      #100;
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] p,
                         input logic [15:0] d, output logic ok);
      logic [8:0] r0, r1, r2, r3;
      start;
      xfer({a, 1'b0, 1'b1}, r0);
      xfer({p, 1'b1}, r1);
      xfer({d[7:0], 1'b1}, r2);
      xfer({d[15:8], 1'b1}, r3);
      stop;
      ok = !(r0[0] | r1[0] | r2[0] | r3[0]);
   endtask
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] p,
                         output logic [15:0] d, output logic ok);
      logic [8:0] r0, r1, r2, r3, r4;
      start;
      xfer({a, 1'b0, 1'b1}, r0);
      xfer({p, 1'b1}, r1);
      start;
      xfer({a, 1'b1, 1'b1}, r2);
      xfer(9'h1fe, r3);
      xfer(9'h1ff, r4);
      stop;
      d = {r4[8:1], r3[8:1]};
      ok = !(r0[0] | r1[0] | r2[0]);
   endtask
endmodule
`default_nettype wire

// ==== sim/ldc_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module ldc_monitor (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [7:0]  bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic [15:0] bus_rdata,
   input wire logic        scl_in,
   input wire logic        sda_out,
   input wire logic        sda_oe_n,
   input wire logic        int_out,
   input wire logic        int_oe_n,
   input wire logic        irq
);
   logic [2:0] mask_copy;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Mask as last written over the port
   always_ff @(posedge mclk) begin
      if (!rst_n)
         mask_copy <= 3'h0;
      else if (bus_wr && bus_addr == ldc_pkg::REG_MASK)
         mask_copy <= bus_wdata[2:0];
   end
   a_rdata_idle: assert property (
      !$past(bus_rd) |-> bus_rdata == 16'h0000)
      else $error("read data outside answer cycle");
   a_unmapped_zero: assert property (
      $past(bus_rd) && $past(bus_addr) > ldc_pkg::REG_MASK
      |-> bus_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_status_width: assert property (
      $past(bus_rd) && $past(bus_addr) == ldc_pkg::REG_STATUS
      |-> bus_rdata[15:3] == 13'h0000)
      else $error("status has bits beyond three events");
   a_irq_release: assert property (
      $fell(irq) |->
      ($past(bus_rd, 2) && $past(bus_addr, 2) == ldc_pkg::REG_STATUS) ||
      ($past(bus_wr, 2) && $past(bus_addr, 2) == ldc_pkg::REG_MASK))
      else $error("interrupt dropped without clear");
   a_pin_follow: assert property (
      int_oe_n == !irq)
      else $error("interrupt pin disagrees with irq");
   a_open_drain: assert property (
      int_out == 1'b0 && sda_out == 1'b0)
      else $error("open drain pin drives high");
   a_irq_masked: assert property (
      mask_copy == 3'h0 && $past(mask_copy) == 3'h0 |-> !irq)
      else $error("interrupt with all sources masked");
   a_sda_steady: assert property (
      scl_in [*4] |-> $stable(sda_oe_n))
      else $error("data line moved while clock high");
endmodule
bind ldc_top ldc_monitor mon_u (
   .mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
   .irq(irq));
`default_nettype wire

// ==== sim/ldc_top_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module ldc_top_test;
   localparam logic [6:0] dev = ldc_pkg::I2C_ADDR_DEFAULT;
   logic        mclk;
   logic        rst_n;
   logic [7:0]  bus_addr;
   logic [15:0] bus_wdata;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic [15:0] bus_rdata;
   logic        scl;
   logic        host_pull;
   wire         sda_line;
   logic        sda_out;
   logic        sda_oe_n;
   logic        bb_pulse = 1'b0;
   logic        ir_pulse = 1'b0;
   logic        int_out;
   logic        int_oe_n;
   logic        irq;
   logic [15:0] v;
   logic        ok;
   int          failures = 0;
   int          cmp_count = 0;
   // Address, write flag, write data, expected read data
   logic [40:0] regs [14] = '{
      {8'h08, 1'b0, 16'h0000, 16'h0000}, {8'h02, 1'b0, 16'h0000, 16'h0001},
      {8'h03, 1'b0, 16'h0000, 16'h0001}, {8'h04, 1'b0, 16'h0000, 16'h0000},
      {8'h05, 1'b0, 16'h0000, 16'hffff}, {8'h06, 1'b0, 16'h0000, 16'h0000},
      {8'h07, 1'b0, 16'h0000, 16'hffff}, {8'h09, 1'b0, 16'h0000, 16'h0000},
      {8'h0a, 1'b0, 16'h0000, 16'h0000}, {8'hff, 1'b0, 16'h0000, 16'h0000},
      {8'h09, 1'b1, 16'h0007, 16'h0007}, {8'h03, 1'b1, 16'h0003, 16'h0003},
      {8'h0a, 1'b1, 16'h1234, 16'h0000}, {8'h01, 1'b1, 16'h1234, 16'h0000}};
   // Broadband count per period, expected status
   logic [10:0] convs [12] = '{
      {8'h07, 3'h1}, {8'h0b, 3'h3}, {8'h04, 3'h3}, {8'h0a, 3'h1},
      {8'h05, 3'h1}, {8'h07, 3'h1}, {8'h0b, 3'h1}, {8'h07, 3'h1},
      {8'h04, 3'h1}, {8'h0b, 3'h1}, {8'h0b, 3'h5}, {8'h0b, 3'h5}};
   // Released line floats high through the pull-up
   assign sda_line = !host_pull && (sda_oe_n || sda_out);
   ldc_top #(.step_cycles(200)) dut_u (
      .mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bb_pulse(bb_pulse),
      .ir_pulse(ir_pulse), .int_out(int_out), .int_oe_n(int_oe_n),
      .irq(irq));
   ldc_i2c_host host_u (.scl(scl), .sda_pull(host_pull), .sda(sda_line));
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bwr(input logic [7:0] a, input logic [15:0] d);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic brd(input logic [7:0] a, output logic [15:0] d);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
      @(posedge mclk);
   endtask
   task automatic wait_irq;
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (irq !== 1'b1 && n < 800);
      chk("irq wait", 16'h0001, {15'h0000, irq});
      @(posedge mclk);
   endtask
   task automatic pulses(input int nb, input int ni);
      for (int i = 0; i < nb || i < ni; i++) begin
         bb_pulse <= (i < nb);
         ir_pulse <= (i < ni);
         repeat (2) @(posedge mclk);
         bb_pulse <= 1'b0;
         ir_pulse <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask
   task automatic run_period(input int nb, input int ni);
      pulses(nb, ni);
      wait_irq;
      brd(ldc_pkg::REG_STATUS, v);
   endtask
   // Align to a fresh period so pulses land in one window
   task automatic sync;
      brd(ldc_pkg::REG_STATUS, v);
      wait_irq;
      brd(ldc_pkg::REG_STATUS, v);
   endtask
   task automatic run_rows(input int a, input int b);
      for (int i = a; i < b; i++) begin
         run_period(convs[i][10:3], convs[i][10:4]);
         chk("status", {13'h0000, convs[i][2:0]}, v);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      #1000000;
      failures++;
      $display("unexpected run time expected end seen hang");
      give_verdict;
   end
   initial begin
      rst_n = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 16'h0000;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 14; i++) begin
         if (regs[i][32])
            bwr(regs[i][40:33], regs[i][31:16]);
         brd(regs[i][40:33], v);
         chk("register", regs[i][15:0], v);
      end
      $display("test registers done");
      bwr(ldc_pkg::REG_MASK, 16'h0001);
      sync;
      run_period(25, 9);
      chk("status", 16'h0001, v);
      brd(ldc_pkg::REG_BB_DATA, v);
      chk("broadband", 16'h0019, v);
      brd(ldc_pkg::REG_IR_DATA, v);
      chk("infrared", 16'h0009, v);
      brd(ldc_pkg::REG_BB_DATA, v);
      chk("broadband held", 16'h0019, v);
      run_period(0, 0);
      brd(ldc_pkg::REG_BB_DATA, v);
      chk("restart", 16'h0000, v);
      $display("test conversion done");
      bwr(ldc_pkg::REG_IMM_HIGH, 16'h000a);
      sync;
      bwr(ldc_pkg::REG_MASK, 16'h0002);
      pulses(12, 0);
      repeat (450) @(posedge mclk);
      #1 chk("irq held", 16'h0001, {15'h0000, irq});
      chk("pin low", 16'h0000, {15'h0000, int_oe_n});
      @(posedge mclk);
      brd(ldc_pkg::REG_STATUS, v);
      chk("status", 16'h0003, v);
      #1 chk("pin free", 16'h0001, {15'h0000, int_oe_n});
      @(posedge mclk);
      $display("test interrupt hold done");
      bwr(ldc_pkg::REG_IMM_LOW, 16'h0005);
      bwr(ldc_pkg::REG_MASK, 16'h0001);
      sync;
      run_rows(0, 5);
      $display("test immediate limits done");
      host_u.wr_reg(dev, ldc_pkg::REG_PERS_LOW, 16'h0005, ok);
      chk("ack low", 16'h0001, {15'h0000, ok});
      host_u.wr_reg(dev, ldc_pkg::REG_PERS_HIGH, 16'h000a, ok);
      chk("ack high", 16'h0001, {15'h0000, ok});
      host_u.wr_reg(dev ^ 7'h01, ldc_pkg::REG_PERS_HIGH, 16'h00aa, ok);
      chk("foreign ack", 16'h0000, {15'h0000, ok});
      host_u.rd_reg(dev, ldc_pkg::REG_PERS_LOW, v, ok);
      chk("serial read", 16'h0005, v);
      chk("read ack", 16'h0001, {15'h0000, ok});
      @(posedge mclk);
      brd(ldc_pkg::REG_PERS_HIGH, v);
      chk("upper limit", 16'h000a, v);
      bwr(ldc_pkg::REG_IMM_LOW, 16'h0000);
      bwr(ldc_pkg::REG_IMM_HIGH, 16'hffff);
      sync;
      run_rows(5, 12);
      $display("test persistence done");
      bwr(ldc_pkg::REG_CTRL, 16'h0011);
      sync;
      run_period(60, 0);
      brd(ldc_pkg::REG_BB_DATA, v);
      chk("two step window", 16'h003c, v);
      wait_irq;
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk("reset irq", 16'h0000, {15'h0000, irq});
      chk("reset pin", 16'h0001, {15'h0000, int_oe_n});
      @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      brd(ldc_pkg::REG_MASK, v);
      chk("mask reset", 16'h0000, v);
      $display("test reset done");
      give_verdict;
   end
endmodule
`default_nettype wire
